/* rtl/ids_pkg.sv */
/*
 * Constants and carrier types for the ISA DMA and interrupt sideband block.
 * Assumes one 40 MHz clock, APB register access and a DMA core on the same clock.
 */
// Overview of operation
// (R1) Take DMA requests on channels 0-3 and 5-7, also as 16-bit ISA master bids.
// (R2) DMA request polarity comes from the command register polarity bit.
// (R3) Requester holds its request until its acknowledge is given.
// (R4) No acknowledge when the request is gone before the grant.
// (R5) Acknowledges 1-3 and 5-7 answer own request, high during and after reset.
// (R6) Channel 0 ack pin low at reset enables claiming the fixed memory range.
// (R7) Terminal count rises after address output when byte count expires.
// (R8) Terminal count holds until AEN falls; auto-init drops it before AEN.
// (R9) Refresh driven low only while own DMA serves an internal refresh.
// (R10) Refresh pin is an input during external ISA master cycles.
// (R11) PC/PCI DMA requested on its own output, granted on its own input.
// (R12) Each interrupt edge or high-level sensed, edge after reset; level twelve cannot be set to high-level.
// (R13) Request gone before acknowledge answers with vector seven.
// (R14) Mouse mode latches a rising edge on pin twelve as level twelve.
// (R15) Mouse latch holds until reset or an I/O read of port 60h.
// (R16) Interrupt requests go to the host over one serial two-way line.
// (R17) ISA system clock is the bus clock divided by four, always running; the divider stops while CE is low.
// (R18) Bus-side inputs sampled on the rising clock edge.
// (R19) External ISA master takes the bus with master line plus DMA request.
// (R20) Asynchronous requests and interrupts pass two flip-flops first.
package ids_pkg;
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_IRQ_MODE  = 12'h004;
   localparam logic [11:0] ADDR_STATUS    = 12'h008;
   localparam logic [11:0] ADDR_IRQ_REQ   = 12'h00c;
   localparam int          CTRL_DREQ_LOW  = 0;
   localparam int          CTRL_MOUSE     = 1;
   localparam logic [1:0]  CTRL_RESET     = 2'h0;
   localparam logic [15:0] IRQ_MODE_RESET = 16'h0000;
   localparam logic [15:0] IRQ_VALID      = 16'hcef8;
   localparam logic [7:0]  DREQ_VALID     = 8'hef;
   localparam logic [3:0]  SPURIOUS_LEVEL = 4'h7;
   localparam int          MOUSE_LEVEL    = 12;
   localparam logic [15:0] KBD_DATA_PORT  = 16'h0060;
   localparam logic [31:0] CLAIM_LOW      = 32'h0fff0000;
   localparam logic [31:0] CLAIM_HIGH     = 32'h0fffffff;
   localparam logic [1:0]  SYSCLK_DIV_TOP = 2'h3;
   localparam logic [2:0]  SIRQ_START_MIN = 3'h4;
   localparam logic [3:0]  SIRQ_LAST_SLOT = 4'hf;
   localparam logic [1:0]  SIRQ_LAST_PH   = 2'h2;

   typedef struct packed {
      logic       aen;
      logic       addr_strobe;
      logic       count_expire;
      logic       autoinit;
      logic       chan_done;
      logic       refresh_req;
   } ids_dma_core_t;

   typedef struct packed {
      logic        strobe;
      logic [15:0] addr;
   } ids_io_read_t;

   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_ACK  = 2'b01
   } ids_arb_t;

   typedef enum logic [1:0] {
      SIRQ_IDLE  = 2'b00,
      SIRQ_START = 2'b01,
      SIRQ_SLOT  = 2'b11
   } ids_sirq_t;
endpackage

/* rtl/ids_sideband.sv */
/*
 * ISA DMA acknowledge, terminal count, refresh, PC/PCI request, interrupt sensing,
 * mouse latch, serial interrupt output and ISA clock divider with APB registers.
 * Assumes the DMA core and ISA decode run on SYS_CLK; pins are asynchronous.
 */
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module ids_sideband
   import ids_pkg::*;
(
   input  wire logic          SYS_CLK,
   input  wire logic          SRST,
   input  wire logic          CE,
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [11:0]   PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic      [31:0]   PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   input  wire logic [7:0]    DREQ_PIN,
   input  wire logic          MASTER_N_PIN,
   input  wire logic          CHAN0_ACK_STRAP_N_I,
   output logic               CHAN0_ACK_STRAP_N_O,
   output logic               CHAN0_ACK_STRAP_N_OE,
   output logic      [7:1]    DACK_N,
   input  wire ids_dma_core_t DMA_CORE,
   output logic               TC,
   input  wire logic          REFRESH_N_I,
   output logic               REFRESH_N_O,
   output logic               REFRESH_N_OE,
   output logic               PCPCI_DMA_REQUEST_N,
   input  wire logic          PCPCI_DMA_GRANT_N,
   input  wire logic [31:0]   MEM_ADDR,
   output logic               MEM_CLAIM,
   input  wire logic [15:0]   IRQ_PIN,
   input  wire logic          IRQ_TWELVE_MOUSE_PIN,
   input  wire ids_io_read_t  IO_READ,
   input  wire logic          INTA_STROBE,
   input  wire logic [3:0]    INTA_LEVEL,
   output logic      [3:0]    INTA_VECTOR,
   input  wire logic          SERIRQ_I,
   output logic               SERIRQ_O,
   output logic               SERIRQ_OE,
   output logic               SYSCLK
);
   logic [7:0]  dreq_s1, dreq_s2;
   logic [15:0] irq_s1, irq_s2, irq_d;
   logic        master_s1, master_s2, refr_s1, refr_s2, strap_s1, strap_s2;
   logic [1:0]  ctrl;
   logic [15:0] irq_mode;
   logic        claim_en;
   logic [7:0]  req_act;
   ids_arb_t    arb_state;
   logic [2:0]  ack_chan;
   logic        pcpci_req;
   logic        mouse_latch;
   logic [15:0] edge_flag, irq_req;
   ids_sirq_t   sirq_state;
   logic [2:0]  low_cnt;
   logic [3:0]  slot;
   logic [1:0]  phase;
   logic [15:0] sirq_snap;
   logic [1:0]  div_cnt = 2'h0;
   logic        acc_wr, acc_rd, addr_hit;
   logic [2:0]  next_chan;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   // Two-stage synchronisers for pins
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         dreq_s1   <= 8'h00;
         dreq_s2   <= 8'h00;
         irq_s1    <= 16'h0000;
         irq_s2    <= 16'h0000;
         master_s1 <= 1'b1;
         master_s2 <= 1'b1;
         refr_s1   <= 1'b1;
         refr_s2   <= 1'b1;
      end else if (CE) begin
         dreq_s1   <= DREQ_PIN;                                   // R20
         dreq_s2   <= dreq_s1;
         irq_s1    <= {IRQ_PIN[15:13], IRQ_TWELVE_MOUSE_PIN, IRQ_PIN[11:0]}; // R20
         irq_s2    <= irq_s1;
         master_s1 <= MASTER_N_PIN;
         master_s2 <= master_s1;
         refr_s1   <= REFRESH_N_I;
         refr_s2   <= refr_s1;
      end
   end

   // Strap pin sampled throughout reset
   always_ff @(posedge SYS_CLK) begin
      if (CE) begin
         strap_s1 <= CHAN0_ACK_STRAP_N_I;
         strap_s2 <= strap_s1;
         if (SRST) begin
            claim_en <= ~strap_s2;                                // R6
         end
      end
   end

   assign MEM_CLAIM = claim_en && MEM_ADDR >= CLAIM_LOW && MEM_ADDR <= CLAIM_HIGH; // R6

   // APB slave, zero wait states
   assign acc_wr   = PSEL && PENABLE && PWRITE;
   assign acc_rd   = PSEL && PENABLE && !PWRITE;
   assign addr_hit = PADDR == ADDR_CTRL || PADDR == ADDR_IRQ_MODE || PADDR == ADDR_STATUS
                     || PADDR == ADDR_IRQ_REQ;
   assign PREADY   = 1'b1;
   assign PSLVERR  = PSEL && PENABLE && !addr_hit;

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         ctrl     <= CTRL_RESET;
         irq_mode <= IRQ_MODE_RESET;                              // R12
      end else if (CE && acc_wr) begin
         if (PADDR == ADDR_CTRL) begin
            ctrl <= PWDATA[1:0];                                  // R2
         end
         if (PADDR == ADDR_IRQ_MODE) begin
            irq_mode <= PWDATA[15:0] & IRQ_VALID;                 // R12
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         PRDATA <= 32'h00000000;
      end else if (CE && acc_rd) begin
         unique case (PADDR)
            ADDR_CTRL:     PRDATA <= {30'h00000000, ctrl};
            ADDR_IRQ_MODE: PRDATA <= {16'h0000, irq_mode};
            ADDR_STATUS:   PRDATA <= {16'h0000, req_act, ~refr_s2, ack_chan, mouse_latch, TC, // R10
                                      ~master_s2, claim_en};
            ADDR_IRQ_REQ:  PRDATA <= {16'h0000, irq_req};
            default:       PRDATA <= 32'h00000000;
         endcase
      end
   end

   // Request polarity and channel choice
   assign req_act = (dreq_s2 ^ {8{ctrl[CTRL_DREQ_LOW]}}) & DREQ_VALID; // R1 R2

   always_comb begin
      next_chan = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (req_act[i]) begin
            next_chan = i[2:0];
         end
      end
   end

   // Acknowledge arbiter; grant only to a request still present
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         arb_state <= ARB_IDLE;
         ack_chan  <= 3'h0;
         pcpci_req <= 1'b0;
      end else if (CE) begin
         unique case (arb_state)
            ARB_IDLE: begin
               pcpci_req <= |req_act;                             // R11
               if (|req_act && pcpci_req && !PCPCI_DMA_GRANT_N) begin // R4 R18
                  arb_state <= ARB_ACK;
                  ack_chan  <= next_chan;                         // R1 R19
                  pcpci_req <= 1'b0;
               end
            end
            ARB_ACK: begin
               if (DMA_CORE.chan_done || !req_act[ack_chan]) begin // R3
                  arb_state <= ARB_IDLE;
               end
            end
         endcase
      end
   end

   assign PCPCI_DMA_REQUEST_N = ~pcpci_req;                      // R11

   always_comb begin
      DACK_N = 7'h7f;
      CHAN0_ACK_STRAP_N_O  = 1'b1;
      CHAN0_ACK_STRAP_N_OE = 1'b0;
      if (arb_state == ARB_ACK) begin
         if (ack_chan == 3'h0) begin
            CHAN0_ACK_STRAP_N_O  = 1'b0;
            CHAN0_ACK_STRAP_N_OE = 1'b1;
         end else begin
            DACK_N[ack_chan] = 1'b0;                              // R5
         end
      end
   end

   // Terminal count
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         TC <= 1'b0;
      end else if (CE) begin
         if (DMA_CORE.addr_strobe && DMA_CORE.count_expire) begin
            TC <= 1'b1;                                           // R7
         end else if (!DMA_CORE.aen || DMA_CORE.autoinit) begin
            TC <= 1'b0;                                           // R8
         end
      end
   end

   // Refresh driver, released while an external master owns the bus
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         REFRESH_N_OE <= 1'b0;
      end else if (CE) begin
         REFRESH_N_OE <= DMA_CORE.refresh_req && master_s2;       // R9 R10
      end
   end
   assign REFRESH_N_O = 1'b0;                                     // R9

   // Interrupt sensing per line
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         irq_d <= 16'h0000;
      end else if (CE) begin
         irq_d <= irq_s2;
      end
   end

   for (genvar g = 0; g < 16; g++) begin : g_irq
      always_ff @(posedge SYS_CLK) begin
         if (SRST) begin
            edge_flag[g] <= 1'b0;
         end else if (CE) begin
            if (irq_s2[g] && !irq_d[g]) begin
               edge_flag[g] <= 1'b1;                              // R12
            end else if (!irq_s2[g] || (INTA_STROBE && INTA_LEVEL == 4'(g))) begin
               edge_flag[g] <= 1'b0;
            end
         end
      end
      if (g == MOUSE_LEVEL) begin : g_mouse
         assign irq_req[g] = ctrl[CTRL_MOUSE] ? mouse_latch :       // R14
                             (irq_mode[g] ? irq_s2[g] : edge_flag[g]);
      end else begin : g_plain
         assign irq_req[g] = IRQ_VALID[g] && (irq_mode[g] ? irq_s2[g] : edge_flag[g]); // R12
      end
   end

   // Mouse latch; a new edge wins over the port read
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         mouse_latch <= 1'b0;                                     // R15
      end else if (CE) begin
         if (ctrl[CTRL_MOUSE] && irq_s2[MOUSE_LEVEL] && !irq_d[MOUSE_LEVEL]) begin
            mouse_latch <= 1'b1;                                  // R14
         end else if (IO_READ.strobe && IO_READ.addr == KBD_DATA_PORT) begin
            mouse_latch <= 1'b0;                                  // R15
         end
      end
   end

   // Acknowledge vector
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         INTA_VECTOR <= SPURIOUS_LEVEL;
      end else if (CE && INTA_STROBE) begin
         INTA_VECTOR <= irq_req[INTA_LEVEL] ? INTA_LEVEL : SPURIOUS_LEVEL; // R13
      end
   end

   // Serial interrupt frame: start pulse, then 16 three-phase slots
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         sirq_state <= SIRQ_IDLE;
         low_cnt    <= 3'h0;
         slot       <= 4'h0;
         phase      <= 2'h0;
         sirq_snap  <= 16'h0000;
         SERIRQ_O   <= 1'b1;
         SERIRQ_OE  <= 1'b0;
      end else if (CE) begin
         unique case (sirq_state)
            SIRQ_IDLE: begin
               SERIRQ_OE <= 1'b0;
               if (!SERIRQ_I) begin                               // R18
                  sirq_state <= SIRQ_START;
                  low_cnt    <= 3'h1;
               end
            end
            SIRQ_START: begin
               if (!SERIRQ_I) begin
                  low_cnt <= (low_cnt == SIRQ_START_MIN) ? low_cnt : low_cnt + 3'h1;
               end else if (low_cnt >= SIRQ_START_MIN) begin
                  sirq_state <= SIRQ_SLOT;
                  slot       <= 4'h0;
                  phase      <= 2'h0;
                  sirq_snap  <= irq_req;
               end else begin
                  sirq_state <= SIRQ_IDLE;
               end
            end
            SIRQ_SLOT: begin
               SERIRQ_OE <= (phase != SIRQ_LAST_PH) && sirq_snap[slot]; // R16
               SERIRQ_O  <= phase != 2'h0;
               if (phase == SIRQ_LAST_PH) begin
                  phase <= 2'h0;
                  if (slot == SIRQ_LAST_SLOT) begin
                     sirq_state <= SIRQ_IDLE;
                  end else begin
                     slot <= slot + 4'h1;
                  end
               end else begin
                  phase <= phase + 2'h1;
               end
            end
            default: begin
               sirq_state <= SIRQ_IDLE;
            end
         endcase
      end
   end

   // ISA clock divider, runs through reset
   always_ff @(posedge SYS_CLK) begin
      if (CE) begin
         div_cnt <= div_cnt + 2'h1;                               // R17
         SYSCLK  <= div_cnt[1];
      end
   end

   sequence s_addr_expire;
      CE && DMA_CORE.addr_strobe && DMA_CORE.count_expire;
   endsequence

   sequence s_three_quiet;
      !$rose(SYSCLK) [*3];
   endsequence

   a_idle_no_ack: assert property (arb_state == ARB_IDLE |-> DACK_N == 7'h7f && !CHAN0_ACK_STRAP_N_OE) // R5
      else $error("acknowledge active while arbiter idle");
   a_ack_needs_req: assert property ($rose(arb_state == ARB_ACK) |-> $past(req_act[next_chan]) // R4
      && $past(!PCPCI_DMA_GRANT_N)) else $error("acknowledge without live request and grant");
   a_tc_sets: assert property (s_addr_expire |=> TC) // R7
      else $error("terminal count not raised");
   a_tc_drops: assert property (CE && !DMA_CORE.aen && !DMA_CORE.addr_strobe |=> !TC) // R8
      else $error("terminal count held after address enable fell");
   a_refresh_owner: assert property (REFRESH_N_OE |-> $past(DMA_CORE.refresh_req) && $past(master_s2)) // R9
      else $error("refresh driven without internal refresh");
   a_mouse_holds: assert property (mouse_latch && !(IO_READ.strobe && IO_READ.addr == KBD_DATA_PORT) // R15
      |=> mouse_latch) else $error("mouse latch lost");
   a_spurious_vec: assert property (CE && INTA_STROBE && !irq_req[INTA_LEVEL] |=> INTA_VECTOR == SPURIOUS_LEVEL) // R13
      else $error("withdrawn request not reported as seven");
   a_sysclk_period: assert property ($rose(SYSCLK) |=> s_three_quiet) // R17
      else $error("system clock faster than divide by four");
   a_sirq_slot_only: assert property (SERIRQ_OE |-> $past(sirq_state) == SIRQ_SLOT) // R16
      else $error("serial line driven outside a slot");
   a_pcpci_req: assert property (!PCPCI_DMA_REQUEST_N |-> $past(|req_act)) // R11
      else $error("PC/PCI request without DMA request");
endmodule

/* bench/ids_far_model.sv */
/* Far-side model: DMA requesters, ISA master and PC/PCI grant source.
   Assumes bench commands on the same clock. */
`timescale 1ns/1ps
module ids_far_model (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [7:0] req_cmd,
   input  wire logic [7:0] drop_cmd,
   input  wire logic       active_low,
   input  wire logic       master_mode,
   input  wire logic       request_n,
   input  wire logic [3:0] grant_delay,
   output logic      [7:0] dreq_pin,
   output logic            master_n,
   output logic            grant_n
);
   logic [7:0] pend;
   logic [3:0] wait_cnt;
   // Request held until told to withdraw
   always_ff @(posedge clk) begin
      if (srst)
         pend <= 8'h00;
      else
         pend <= (pend | req_cmd) & ~drop_cmd;
   end
   assign dreq_pin = active_low ? ~pend : pend;
   assign master_n = ~(master_mode & (|pend));
   // Grant after a set wait
   always_ff @(posedge clk) begin
      if (srst || request_n) begin
         wait_cnt <= 4'h0;
         grant_n  <= 1'b1;
      end else if (wait_cnt >= grant_delay)
         grant_n <= 1'b0;
      else
         wait_cnt <= wait_cnt + 4'h1;
   end
endmodule

/* bench/isa_dma_irq_sideband_bench.sv */
/* Self-checking bench for the sideband block.
   Assumes ids_far_model as requester and grant source; pull-ups on shared pins. */
`timescale 1ns/1ps
module isa_dma_irq_sideband_bench import ids_pkg::*;;
   logic          clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwr = 1'b0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0, prdata, mem_addr = 32'h0, q, seed = 32'h5392a595;
   logic          pready, pslverr, master_n, strap_i, ch0_o, ch0_oe, tc, ref_i, ref_o, ref_oe;
   logic          req_n, gnt_n, claim, sirq_i, sirq_o, sirq_oe, sysclk, e;
   logic          mouse = 1'b0, inta_stb = 1'b0, act_low = 1'b0, mmode = 1'b0;
   logic          strap_n = 1'b0, host_low = 1'b0, ext_ref = 1'b0, ce = 1'b1;
   logic [7:0]    dreq, ack_n, req_cmd = 8'h00, drop_cmd = 8'h00;
   logic [7:1]    dack;
   logic [15:0]   irq = 16'h0;
   logic [3:0]    inta_lvl = 4'h0, inta_vec, gdelay = 4'h0;
   ids_dma_core_t core = '0;
   ids_io_read_t  ior = '0;
   int            n_errors = 0, samples_checked = 0, k, lv;
   int            ch_list [7] = '{0, 1, 2, 3, 5, 6, 7};
   int            irq_list [9] = '{3, 4, 5, 6, 9, 10, 11, 14, 15};
   logic [31:0]   a_list [5];

   always #12.5 clk = ~clk;
   assign strap_i = ch0_oe ? ch0_o : strap_n;
   assign ref_i   = ref_oe ? ref_o : ~ext_ref;
   assign sirq_i  = host_low ? 1'b0 : (sirq_oe ? sirq_o : 1'b1);
   assign ack_n   = {dack, strap_i};

   ids_sideband dut (.SYS_CLK(clk), .SRST(srst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DREQ_PIN(dreq),
      .MASTER_N_PIN(master_n), .CHAN0_ACK_STRAP_N_I(strap_i), .CHAN0_ACK_STRAP_N_O(ch0_o),
      .CHAN0_ACK_STRAP_N_OE(ch0_oe), .DACK_N(dack), .DMA_CORE(core), .TC(tc), .REFRESH_N_I(ref_i),
      .REFRESH_N_O(ref_o), .REFRESH_N_OE(ref_oe), .PCPCI_DMA_REQUEST_N(req_n), .PCPCI_DMA_GRANT_N(gnt_n),
      .MEM_ADDR(mem_addr), .MEM_CLAIM(claim), .IRQ_PIN(irq), .IRQ_TWELVE_MOUSE_PIN(mouse), .IO_READ(ior),
      .INTA_STROBE(inta_stb), .INTA_LEVEL(inta_lvl), .INTA_VECTOR(inta_vec), .SERIRQ_I(sirq_i),
      .SERIRQ_O(sirq_o), .SERIRQ_OE(sirq_oe), .SYSCLK(sysclk));
   ids_far_model far (.clk(clk), .srst(srst), .req_cmd(req_cmd), .drop_cmd(drop_cmd), .active_low(act_low),
      .master_mode(mmode), .request_n(req_n), .grant_delay(gdelay), .dreq_pin(dreq), .master_n(master_n),
      .grant_n(gnt_n));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic claim_exp(input logic [31:0] a, input logic en);
      return en && a >= CLAIM_LOW && a <= CLAIM_HIGH;
   endfunction
   function automatic logic [3:0] vec_exp(input int l, input logic pend);
      return pend ? 4'(l) : SPURIOUS_LEVEL;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (!ok) begin
         n_errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic bound(input logic ok);
      chk(ok, "wait ran out");
      if (!ok)
         wrap_up();
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1'b1;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (pready !== 1'b1 && n < 20);
      bound(pready === 1'b1);
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tick(1);
      q = prdata;
   endtask
   task automatic dma_one(input int ch);
      req_cmd <= 8'h1 << ch;
      tick(1);
      req_cmd <= 8'h00;
      for (k = 0; k < 10 && req_n !== 1'b0; k++) tick(1);
      bound(req_n === 1'b0);
      for (k = 0; k < 40 && ack_n[ch] !== 1'b0; k++) tick(1);
      bound(ack_n[ch] === 1'b0);
      chk((ack_n | (8'h1 << ch)) === 8'hff, "other ack");
      core.chan_done <= 1'b1;
      drop_cmd <= 8'h1 << ch;
      tick(1);
      core.chan_done <= 1'b0;
      drop_cmd <= 8'h00;
      tick(3);
      chk(ack_n === 8'hff, "ack stuck");
   endtask
   task automatic inta(input int l, input logic pend);
      inta_lvl <= 4'(l);
      inta_stb <= 1'b1;
      tick(1);
      inta_stb <= 1'b0;
      tick(1);
      chk(inta_vec === vec_exp(l, pend), "vector");
   endtask
   task automatic tc_set();
      core.addr_strobe <= 1'b1;
      core.count_expire <= 1'b1;
      tick(1);
      core.addr_strobe <= 1'b0;
      core.count_expire <= 1'b0;
      tick(1);
      chk(tc === 1'b1, "tc set");
   endtask
   task automatic io_rd(input logic [15:0] a);
      ior <= {1'b1, a};
      tick(1);
      ior.strobe <= 1'b0;
      tick(2);
   endtask

   initial begin
      seed = lfsr(seed);
      a_list = '{CLAIM_LOW, CLAIM_HIGH, CLAIM_LOW - 32'h1, CLAIM_HIGH + 32'h1, CLAIM_LOW | seed[15:0]};
      tick(3);
      q[0] = sysclk;
      tick(2);
      q[1] = sysclk;
      tick(2);
      chk(q[1] !== q[0] && sysclk === q[0], "clock divide");
      chk({dack, ch0_oe, tc, ref_oe, req_n, sirq_oe} === 12'hfe2, "reset outputs");
      ce <= 1'b0;
      tick(2);
      q[0] = sysclk;
      tick(3);
      chk(sysclk === q[0], "clock enable freeze");
      ce <= 1'b1;
      tick(4);
      srst <= 1'b0;
      strap_n <= 1'b1;
      tick(2);
      chk({dack, ch0_oe, tc, ref_oe, req_n, inta_vec} === {11'h7f1, SPURIOUS_LEVEL}, "idle outputs");
      for (int i = 0; i < 5; i++) begin
         mem_addr <= a_list[i];
         tick(2);
         chk(claim === claim_exp(a_list[i], 1'b1), "claim");
      end
      seed = lfsr(seed);
      apb(1'b1, ADDR_IRQ_MODE, seed);
      apb(1'b0, ADDR_IRQ_MODE, 32'h0);
      chk(q === {16'h0, seed[15:0] & IRQ_VALID}, "mode readback");
      apb(1'b1, 12'h010, 32'h0);
      chk(e === 1'b1, "unmapped");
      apb(1'b1, ADDR_IRQ_MODE, 32'h0);
      seed = lfsr(seed);
      for (int i = 0; i < 7; i++) begin
         gdelay <= {2'b00, seed[2 * i +: 2]};
         dma_one(ch_list[(i + int'(seed[18:16])) % 7]);
      end
      gdelay <= 4'hf;
      act_low <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h1);
      tick(20);
      gdelay <= 4'h2;
      dma_one(6);
      gdelay <= 4'hf;
      act_low <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h0);
      tick(20);
      req_cmd <= 8'h04;
      tick(8);
      req_cmd <= 8'h00;
      drop_cmd <= 8'h04;
      e = 1'b1;
      for (int i = 0; i < 30; i++) begin
         tick(1);
         drop_cmd <= 8'h00;
         e = e & (ack_n === 8'hff);
      end
      chk(e === 1'b1, "ack after withdraw");
      core.aen <= 1'b1;
      core.addr_strobe <= 1'b1;
      tick(1);
      core.addr_strobe <= 1'b0;
      tick(1);
      chk(tc === 1'b0, "tc early");
      tc_set();
      tick(5);
      chk(tc === 1'b1, "tc hold");
      core.aen <= 1'b0;
      tick(2);
      chk(tc === 1'b0, "tc after aen");
      core.aen <= 1'b1;
      tc_set();
      core.autoinit <= 1'b1;
      tick(2);
      chk(tc === 1'b0 && core.aen === 1'b1, "tc autoinit");
      core <= '{refresh_req: 1'b1, default: 1'b0};
      tick(4);
      chk(ref_oe === 1'b1 && ref_i === 1'b0, "refresh drive");
      core.refresh_req <= 1'b0;
      tick(3);
      chk(ref_oe === 1'b0, "refresh release");
      mmode <= 1'b1;
      req_cmd <= 8'h20;
      tick(5);
      req_cmd <= 8'h00;
      core.refresh_req <= 1'b1;
      tick(4);
      chk(ref_oe === 1'b0, "refresh under master");
      core.refresh_req <= 1'b0;
      drop_cmd <= 8'h20;
      tick(1);
      drop_cmd <= 8'h00;
      ext_ref <= 1'b1;
      tick(3);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q[7] === 1'b1, "refresh input");
      ext_ref <= 1'b0;
      mmode <= 1'b0;
      tick(20);
      seed = lfsr(seed);
      lv = irq_list[seed[3:0] % 9];
      irq[lv] <= 1'b1;
      tick(5);
      inta(lv, 1'b1);
      inta(lv, 1'b0);
      irq[lv] <= 1'b0;
      tick(3);
      irq[lv] <= 1'b1;
      tick(5);
      irq[lv] <= 1'b0;
      tick(5);
      inta(lv, 1'b0);
      apb(1'b1, ADDR_IRQ_MODE, 32'h1 << lv);
      irq[lv] <= 1'b1;
      tick(5);
      inta(lv, 1'b1);
      inta(lv, 1'b1);
      irq[lv] <= 1'b0;
      tick(5);
      inta(lv, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      mouse <= 1'b1;
      tick(2);
      mouse <= 1'b0;
      tick(5);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q[3] === 1'b1, "mouse latch");
      inta(MOUSE_LEVEL, 1'b1);
      io_rd(16'h0064);
      inta(MOUSE_LEVEL, 1'b1);
      io_rd(KBD_DATA_PORT);
      inta(MOUSE_LEVEL, 1'b0);
      apb(1'b1, ADDR_IRQ_MODE, 32'h8);
      irq[3] <= 1'b1;
      tick(4);
      host_low <= 1'b1;
      tick(5);
      host_low <= 1'b0;
      for (k = 0; k < 80 && sirq_oe !== 1'b1; k++) tick(1);
      bound(sirq_oe === 1'b1);
      chk(k >= 9 && sirq_o === 1'b0, "slot low");
      tick(1);
      chk(sirq_oe === 1'b1 && sirq_o === 1'b1, "slot high");
      irq[3] <= 1'b0;
      srst <= 1'b1;
      strap_n <= 1'b1;
      tick(4);
      srst <= 1'b0;
      mem_addr <= CLAIM_LOW;
      tick(2);
      chk(claim === 1'b0, "claim strap off");
      wrap_up();
   end
endmodule
